//--- rtl/pid_time_proportioning_core.sv
// Heat/cool PID core with two tuning sets and time-proportioned outputs.
// Assumes a register port with read data one cycle after the read strobe,
// and a process value in signed tenths of a degree, synchronous to clk.
// One channel per core; a multi-channel controller instantiates one per channel.
`timescale 1ns/1ps
`default_nettype none
`include "pid_core_params.svh"
module pid_time_proportioning_core
  import pid_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [15:0] pv_in,
  output logic heat_out,
  output logic cool_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    side_cfg_t [1:0][1:0] cfg;   // [set][side], side 0 heat, 1 cool
    logic [1:0][6:0] dz;         // dead zone per set
    logic stage;
    logic [15:0] span;
    logic [15:0] sp;
    logic [1:0][31:0] acc;
    logic [15:0] pv_prev;
    logic pv_seen;
    logic [1:0] over;
    logic [1:0][9:0] demand;
    logic [15:0] rdata;
  } core_state_t;

  // reset image built once as a constant
  function automatic core_state_t reset_state();
    core_state_t r;
    side_cfg_t c;
    r = '0;
    c = '0;
    c.band = 16'(`RST_BAND);
    c.gain = 16'(`RST_GAIN);
    c.wpct = 7'(`RST_WPCT);
    c.wdeg = 16'(`RST_BAND);
    c.unwind = 10'(`RST_UNWIND);
    c.cycle = 4'(`RST_CYCLE);
    for (int a = 0; a < 2; a++) begin
      for (int b = 0; b < 2; b++) begin
        r.cfg[a][b] = c;
      end
    end
    r.span = 16'(`RST_SPAN);
    return r;
  endfunction : reset_state

  // gain from span over band; a zero band pins the gain at its top value
  function automatic logic [15:0] gain_from_band(input logic [15:0] span_v,
                                                 input logic [15:0] band_v);
    if (band_v == '0) begin
      return 16'(`GAIN_MAX);
    end
    return 16'(sat(quot(int'(span_v), int'(band_v)), 0, `GAIN_MAX));
  endfunction : gain_from_band

  // integral correction in tenths; truncation toward zero treats both signs alike
  function automatic int corr_of(input logic [31:0] acc_v);
    return quot(int'($signed(acc_v)), `ACC_DIV);
  endfunction : corr_of

  localparam core_state_t RESET_STATE = reset_state();

  core_state_t st, next_st;
  logic tick;
  duty_if heat_duty();
  duty_if cool_duty();

  // ----------------------------------------
  // sample tick and output drivers
  // ----------------------------------------
  sample_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // drivers see the demand of the selected stage
  // trade-off: a stage change reaches the period at once, the demand only at wrap
  assign heat_duty.tick = tick;
  assign heat_duty.demand = st.demand[0];
  assign heat_duty.cycle_s = st.cfg[st.stage][0].cycle;
  assign cool_duty.tick = tick;
  assign cool_duty.demand = st.demand[1];
  assign cool_duty.cycle_s = st.cfg[st.stage][1].cycle;

  time_prop_out u_heat (
    .clk(clk),
    .rst(rst),
    .duty(heat_duty),
    .out(heat_out)
  );

  time_prop_out u_cool (
    .clk(clk),
    .rst(rst),
    .duty(cool_duty),
    .out(cool_out)
  );

  // ----------------------------------------
  // register writes, control law, reads
  // ----------------------------------------
  always_comb begin
    int e, el, inc, accv, corr, p, i, d, sum, dzv, band, wl, pv, prev;
    logic set, sd, over_now;
    side_cfg_t c;
    e = 0;
    el = 0;
    inc = 0;
    accv = 0;
    corr = 0;
    p = 0;
    i = 0;
    d = 0;
    sum = 0;
    dzv = 0;
    band = 0;
    wl = 0;
    pv = int'($signed(pv_in));
    prev = int'($signed(st.pv_prev));
    set = addr[`A_SET_BIT];
    sd = addr[`A_SIDE_BIT];
    over_now = 1'b0;
    // addressed set and side; the control law below reuses c for its own sides
    c = st.cfg[set][sd];
    next_st = st;

    // software writes, each field except stage, setpoint and span clamped into its legal range
    if (wr && addr[`A_GLOBAL_BIT]) begin
      case (addr)
        `A_CTRL: next_st.stage = wdata[0];
        `A_SETPOINT: next_st.sp = wdata;
        `A_DZ0: next_st.dz[0] = 7'(sat(int'(wdata), 0, `DZ_MAX));
        `A_DZ1: next_st.dz[1] = 7'(sat(int'(wdata), 0, `DZ_MAX));
        `A_SPAN: begin
          next_st.span = wdata;
          for (int a = 0; a < 2; a++) begin
            for (int b = 0; b < 2; b++) begin
              // bands stay put; every gain follows the new span
              next_st.cfg[a][b].gain = gain_from_band(wdata, st.cfg[a][b].band);
            end
          end
        end
        default: ;
      endcase
    end else if (wr) begin
      case (addr[3:0])
        `F_BAND: begin
          c.band = 16'(sat(int'(wdata), 0, `BAND_MAX));
          c.gain = gain_from_band(st.span, c.band);
        end
        `F_GAIN: begin
          // written gain kept as is; the band follows it
          c.gain = 16'(sat(int'(wdata), `GAIN_MIN, `GAIN_MAX));
          c.band = 16'(sat(quot(int'(st.span), int'(c.gain)), 0, `BAND_MAX));
        end
        `F_IRATE: c.irate = 10'(sat(int'(wdata), 0, `IRATE_MAX));
        `F_WPCT: begin
          c.wpct = (wdata == '0) ? 7'(`PCT_FULL) :
            7'(sat(int'(wdata), `WPCT_MIN, `PCT_FULL));
        end
        `F_UNWIND: c.unwind = 10'(sat(int'(wdata), `UNWIND_MIN, `UNWIND_MAX));
        `F_DRATE: c.drate = 7'(sat(int'(wdata), 0, `DRATE_MAX));
        `F_CLIP: c.clip = 7'(sat(int'(wdata), 0, `CLIP_MAX));
        `F_CYCLE: c.cycle = 4'(sat(int'(wdata), `CYCLE_MIN, `CYCLE_MAX));
        default: ;
      endcase
      next_st.cfg[set][sd] = c;
    end

    // windup limit in degrees follows band and percentage every cycle
    for (int a = 0; a < 2; a++) begin
      for (int b = 0; b < 2; b++) begin
        next_st.cfg[a][b].wdeg = 16'(quot(int'(next_st.cfg[a][b].band) *
          int'(next_st.cfg[a][b].wpct), `PCT_FULL));
      end
    end

    // control law, once per sample tick, on the selected stage
    if (tick) begin
      for (int s = 0; s < 2; s++) begin
        c = st.cfg[st.stage][s];
        band = int'(c.band);
        wl = int'(c.wdeg);
        dzv = int'(st.dz[st.stage]);
        accv = int'($signed(st.acc[s]));
        // heat error is setpoint minus pv, cool error the reverse
        e = (s == 0) ? int'($signed(st.sp)) - pv : pv - int'($signed(st.sp));
        // derivative sees only pv motion, so setpoint steps cause no kick
        if (st.pv_seen) begin
          d = ((s == 0) ? prev - pv : pv - prev) * int'(c.drate) * `DERIV_SCALE;
        end else begin
          d = 0;
        end
        // overshoot: pv beyond setpoint toward this side's far end by the dead zone
        over_now = (e < 0) && (-e >= dzv);
        if (band == 0) begin
          // on/off around the setpoint, no integral carried
          accv = 0;
          sum = (e > 0) ? `PERMILLE : 0;
        end else begin
          el = sat(e, -wl, wl);
          inc = el * int'(c.irate);
          // an increment against the sign of the store unwinds faster
          if ((accv != 0) && ((el < 0) != (accv < 0))) begin
            inc = quot(inc * int'(c.unwind), `UNWIND_DIV);
          end
          if ((e <= band) && (e >= -band)) begin
            accv = sat(accv + inc, -`ACC_MAX, `ACC_MAX);
          end
          // clip once on entering overshoot, not on every tick of it
          if (over_now && !st.over[s]) begin
            accv = accv - quot(accv, `PCT_FULL) * int'(c.clip);
          end
          corr = quot(accv, `ACC_DIV);
          // proportional term dead inside the zone, band shifted by it
          if (e > dzv) begin
            p = e - dzv;
          end else if (e < -dzv) begin
            p = e + dzv;
          end else begin
            p = 0;
          end
          p = quot(p * `PERMILLE, band);
          i = quot(corr * `PERMILLE, band);
          sum = p + i + d;
        end
        next_st.acc[s] = 32'(accv);
        next_st.over[s] = over_now;
        next_st.demand[s] = 10'(sat(sum, 0, `PERMILLE));
      end
      next_st.pv_prev = pv_in;
      next_st.pv_seen = 1'b1;
    end

    // read data valid only in the cycle after the strobe
    // limitation: a pv read returns the live pin, not the last sampled value
    next_st.rdata = '0;
    if (rd && addr[`A_GLOBAL_BIT]) begin
      case (addr)
        `A_CTRL: next_st.rdata = {15'h0000, st.stage};
        `A_SPAN: next_st.rdata = st.span;
        `A_SETPOINT: next_st.rdata = st.sp;
        `A_DZ0: next_st.rdata = {9'h000, st.dz[0]};
        `A_DZ1: next_st.rdata = {9'h000, st.dz[1]};
        `A_PV: next_st.rdata = pv_in;
        `A_HEAT_DEMAND: next_st.rdata = {6'h00, st.demand[0]};
        `A_COOL_DEMAND: next_st.rdata = {6'h00, st.demand[1]};
        `A_STATUS: next_st.rdata = {12'h000, st.over, cool_out, heat_out};
        `A_HEAT_CORR: next_st.rdata = 16'(corr_of(st.acc[0]));
        `A_COOL_CORR: next_st.rdata = 16'(corr_of(st.acc[1]));
        default: next_st.rdata = '0;
      endcase
    end else if (rd) begin
      // per-side reads come from the stored copy, never from the working c
      case (addr[3:0])
        `F_BAND: next_st.rdata = st.cfg[set][sd].band;
        `F_GAIN: next_st.rdata = st.cfg[set][sd].gain;
        `F_IRATE: next_st.rdata = {6'h00, st.cfg[set][sd].irate};
        `F_WPCT: next_st.rdata = {9'h000, st.cfg[set][sd].wpct};
        `F_WDEG: next_st.rdata = st.cfg[set][sd].wdeg;
        `F_UNWIND: next_st.rdata = {6'h00, st.cfg[set][sd].unwind};
        `F_DRATE: next_st.rdata = {9'h000, st.cfg[set][sd].drate};
        `F_CLIP: next_st.rdata = {9'h000, st.cfg[set][sd].clip};
        `F_CYCLE: next_st.rdata = {12'h000, st.cfg[set][sd].cycle};
        default: next_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset restores the factory image in one step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

endmodule : pid_time_proportioning_core
`default_nettype wire

//--- rtl/pid_core_params.svh
// Constants of the time-proportioning PID core: timing, ranges, resets, register map.
// Assumes a 10 MHz clock and a sample tick every 100 ms.
`ifndef PID_CORE_PARAMS_SVH
`define PID_CORE_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 10000000
`define TICK_MS 100
`define TICKS_PER_S (1000 / `TICK_MS)
`define TICKS_PER_MIN (60 * `TICKS_PER_S)
`define IRATE_DIV 100
`define ACC_DIV (`TICKS_PER_MIN * `IRATE_DIV)

// ----------------------------------------
// scaling and ranges (temperatures in tenths)
// ----------------------------------------
`define PERMILLE 1000
`define PCT_FULL 100
`define UNWIND_DIV 10
`define BAND_MAX 999
`define GAIN_MIN 1
`define GAIN_MAX 9999
`define IRATE_MAX 999
`define WPCT_MIN 1
`define UNWIND_MIN 10
`define UNWIND_MAX 999
`define DRATE_MAX 99
`define CLIP_MAX 100
`define CYCLE_MIN 2
`define CYCLE_MAX 15
`define DZ_MAX 99
`define DERIV_SCALE 1
`define ACC_MAX (`BAND_MAX * `ACC_DIV)

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SPAN 4150
`define RST_BAND 60
`define RST_GAIN (`RST_SPAN / `RST_BAND)
`define RST_WPCT 100
`define RST_UNWIND 10
`define RST_CYCLE 2

// ----------------------------------------
// register map
// ----------------------------------------
`define A_GLOBAL_BIT 7
`define A_SET_BIT 5
`define A_SIDE_BIT 4
`define F_BAND 4'h0
`define F_GAIN 4'h1
`define F_IRATE 4'h2
`define F_WPCT 4'h3
`define F_WDEG 4'h4
`define F_UNWIND 4'h5
`define F_DRATE 4'h6
`define F_CLIP 4'h7
`define F_CYCLE 4'h8
`define A_CTRL 8'h80
`define A_SPAN 8'h81
`define A_SETPOINT 8'h82
`define A_DZ0 8'h83
`define A_DZ1 8'h84
`define A_PV 8'h88
`define A_HEAT_DEMAND 8'h89
`define A_COOL_DEMAND 8'h8A
`define A_STATUS 8'h8B
`define A_HEAT_CORR 8'h8C
`define A_COOL_CORR 8'h8D

`endif

//--- rtl/pid_pkg.sv
// Types and shared arithmetic of the PID core.
// Assumes integer math in 32-bit signed ints.
`default_nettype none
package pid_pkg;

  // one side's tuning, held per set and per side
  typedef struct packed {
    logic [15:0] band;
    logic [15:0] gain;
    logic [9:0] irate;
    logic [6:0] wpct;
    logic [15:0] wdeg;
    logic [9:0] unwind;
    logic [6:0] drate;
    logic [6:0] clip;
    logic [3:0] cycle;
  } side_cfg_t;

  // clamp into a range
  function automatic int sat(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : sat

  // divide, zero divisor gives zero
  function automatic int quot(input int n, input int d);
    return (d == 0) ? 0 : n / d;
  endfunction : quot

endpackage : pid_pkg
`default_nettype wire

//--- rtl/duty_if.sv
// Carries one side's demand and period to its time-proportioning driver.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface duty_if;
  logic tick;
  logic [9:0] demand;
  logic [3:0] cycle_s;
  modport src (output tick, output demand, output cycle_s);
  modport sink (input tick, input demand, input cycle_s);
endinterface : duty_if
`default_nettype wire

//--- rtl/sample_tick_gen.sv
// Sample tick divider: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a free-running clock and asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen #(
  parameter int TICK_CYCLES = 1000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_state_t;
  tick_state_t st, next_st;

  // count up the sample period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= 32'(TICK_CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : sample_tick_gen
`default_nettype wire

//--- rtl/time_prop_out.sv
// Time-proportioning driver: on for demand/1000 of each cycle period.
// Assumes demand in permille, latched at cycle start, and period in whole seconds.
`timescale 1ns/1ps
`default_nettype none
`include "pid_core_params.svh"
module time_prop_out
  import pid_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  duty_if.sink duty,
  output logic out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] on_len;
    logic out;
  } prop_state_t;
  prop_state_t st, next_st;

  // latching at cycle start avoids chopped pulses mid-cycle
  always_comb begin
    int per;
    per = sat(int'(duty.cycle_s), `CYCLE_MIN, `CYCLE_MAX) * `TICKS_PER_S;
    next_st = st;
    if (duty.tick) begin
      if (int'(st.cnt) >= per - 1) begin
        next_st.cnt = '0;
        next_st.on_len = 8'(quot(int'(duty.demand) * per, `PERMILLE));
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
    next_st.out = (next_st.cnt < next_st.on_len);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out = st.out;
endmodule : time_prop_out
`default_nettype wire

//--- testbench/pid_core_monitor.sv
// Checker for the PID core: read-back ranges and output timing.
// Assumes it is bound into the core and sees only the core's ports.
`timescale 1ns/1ps
`default_nettype none
module pid_core_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [15:0] pv_in,
  input wire logic heat_out,
  input wire logic cool_out
);
  // ------------
  // read tracking
  // ------------
  // rdata answers one cycle late, so keep the read address
  logic prd;
  logic [7:0] pa;
  logic [3:0] f;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prd <= 1'b0;
      pa <= 8'h00;
    end else begin
      prd <= rd;
      pa <= addr;
    end
  end
  // field of a per-side read; 4'hF means none, as that field is unmapped
  assign f = (prd && pa[7:6] == 2'b00) ? pa[3:0] : 4'hF;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------
  // properties
  // ------------
  heat_hold_a: assert property ($changed(heat_out) |=> $stable(heat_out) [*8])
    else $error("heat output changed between ticks");
  cool_hold_a: assert property ($changed(cool_out) |=> $stable(cool_out) [*8])
    else $error("cool output changed between ticks");
  zero_pct_a: assert property (
    wr && addr == 8'h03 && wdata == 16'h0000 ##1 rd && addr == 8'h03 |=> rdata == 16'h0064)
    else $error("windup percent zero not read as full");
  cycle_range_a: assert property (f == 4'h8 |-> rdata inside {[16'h0002:16'h000F]})
    else $error("cycle period out of range");
  unwind_range_a: assert property (f == 4'h5 |-> rdata inside {[16'h000A:16'h03E7]})
    else $error("unwind factor out of range");
  pct_range_a: assert property (f == 4'h3 |-> rdata inside {[16'h0001:16'h0064]})
    else $error("windup percent out of range");
  rate_range_a: assert property (f == 4'h6 |-> rdata <= 16'h0063)
    else $error("derivative rate out of range");
  zone_range_a: assert property (
    $past(rd) && ($past(addr) == 8'h83 || $past(addr) == 8'h84) |-> rdata <= 16'h0063)
    else $error("dead zone out of range");
  demand_range_a: assert property (prd && pa inside {8'h89, 8'h8A} |-> rdata <= 16'h03E8)
    else $error("demand above full scale");
endmodule : pid_core_monitor
`default_nettype wire

//--- testbench/chamber_model.sv
// Chamber stand-in: process value held at a set level, or drifting by steps.
// Assumes heat and cool outputs are active high; one step every STEP clocks.
`timescale 1ns/1ps
`default_nettype none
module chamber_model #(
  parameter int STEP = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic heat_out,
  input wire logic cool_out,
  input wire logic hold,
  input wire logic [15:0] pv_set,
  input wire logic [15:0] slope,
  output logic [15:0] pv
);
  int cnt;
  // fixed step spacing keeps the change seen per sample tick exact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      pv <= 16'h0000;
    end else if (hold) begin
      cnt <= 0;
      pv <= pv_set;
    end else if (cnt == STEP - 1) begin
      cnt <= 0;
      pv <= pv + slope + {15'h0000, heat_out} - {15'h0000, cool_out};
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : chamber_model
`default_nettype wire

//--- testbench/pid_time_proportioning_core_tb.sv
// Bench for the PID core: register rows, then duty, zone, rate and integral cases.
// Assumes a 10-clock sample tick and the chamber model as process value source.
`timescale 1ns/1ps
`default_nettype none
module pid_time_proportioning_core_tb;
  // ------------
  // harness
  // ------------
  localparam int TICK = 10;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [15:0] d;
    logic [7:0] ra;
    logic [15:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold = 1'b1;
  logic [15:0] pv_set = 16'h0000;
  logic [15:0] slope = 16'h0000;
  logic [15:0] rdata, pv_in, v;
  logic heat_out, cool_out;
  int failures = 0;
  int num_checks = 0;
  int cnt;
  // optional write, then a read back of ra
  row_t rows [23] = '{
    '{1'b0, 8'h00, 16'h0000, 8'h00, 16'h003C},
    '{1'b0, 8'h00, 16'h0000, 8'h01, 16'h0045},
    '{1'b0, 8'h00, 16'h0000, 8'h33, 16'h0064},
    '{1'b0, 8'h00, 16'h0000, 8'h14, 16'h003C},
    '{1'b0, 8'h00, 16'h0000, 8'h25, 16'h000A},
    '{1'b0, 8'h00, 16'h0000, 8'h18, 16'h0002},
    '{1'b0, 8'h00, 16'h0000, 8'h81, 16'h1036},
    '{1'b0, 8'h00, 16'h0000, 8'h90, 16'h0000},
    '{1'b1, 8'h00, 16'h001E, 8'h01, 16'h008A},
    '{1'b1, 8'h03, 16'h0032, 8'h04, 16'h000F},
    '{1'b1, 8'h03, 16'h0000, 8'h03, 16'h0064},
    '{1'b1, 8'h11, 16'h0064, 8'h10, 16'h0029},
    '{1'b1, 8'h28, 16'h0001, 8'h28, 16'h0002},
    '{1'b1, 8'h38, 16'h0010, 8'h38, 16'h000F},
    '{1'b1, 8'h15, 16'h0005, 8'h15, 16'h000A},
    '{1'b1, 8'h35, 16'h03E8, 8'h35, 16'h03E7},
    '{1'b1, 8'h22, 16'h03E8, 8'h22, 16'h03E7},
    '{1'b1, 8'h26, 16'h0064, 8'h26, 16'h0063},
    '{1'b1, 8'h84, 16'h0064, 8'h84, 16'h0063},
    '{1'b1, 8'h17, 16'h0065, 8'h17, 16'h0064},
    '{1'b1, 8'h20, 16'h0000, 8'h21, 16'h270F},
    '{1'b1, 8'h81, 16'h07D0, 8'h11, 16'h0030},
    '{1'b1, 8'h88, 16'h0005, 8'h88, 16'h0000}
  };
  always #50 clk = ~clk;
  pid_time_proportioning_core #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pv_in(pv_in), .heat_out(heat_out),
    .cool_out(cool_out));
  chamber_model #(.STEP(TICK)) i_plant (.clk(clk), .rst(rst), .heat_out(heat_out),
    .cool_out(cool_out), .hold(hold), .pv_set(pv_set), .slope(slope), .pv(pv_in));
  // ------------
  // tasks
  // ------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
    end
  endtask : chk
  // a write, if any, is followed with no gap by the read
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [7:0] ra);
    @(posedge clk);
    if (w) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
    addr <= ra;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : xfer
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d, a);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, 8'h00, 16'h0000, a);
    chk(v, e, $sformatf("reg %h", a));
  endtask : rchk
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk);
  endtask : ticks
  task automatic count_on(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      #1 if (heat_out === 1'b1) cnt++;
    end
  endtask : count_on
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
  // ------------
  // sequence
  // ------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d, rows[i].ra);
      chk(v, rows[i].e, $sformatf("reg %h", rows[i].ra));
    end
    // half demand: on for half of each 20-tick period
    wreg(8'h82, 16'h000F);
    ticks(30);
    rchk(8'h89, 16'h01F4);
    rchk(8'h8A, 16'h0000);
    count_on(400);
    chk(16'(cnt), 16'h00C8, "heat on clocks");
    // dead zone: error inside it, then beyond it
    wreg(8'h83, 16'h0014);
    ticks(2);
    rchk(8'h89, 16'h0000);
    wreg(8'h82, 16'h002D);
    ticks(2);
    rchk(8'h89, 16'h0341);
    // derivative inside the zone: setpoint step, then steady ramps
    wreg(8'h06, 16'h000A);
    wreg(8'h82, 16'h000A);
    ticks(2);
    rchk(8'h89, 16'h0000);
    pv_set <= 16'h000F;
    // a full period at zero demand, so no earlier on-time bends the ramp
    ticks(22);
    hold <= 1'b0;
    slope <= 16'hFFFF;
    ticks(5);
    rchk(8'h89, 16'h000A);
    ticks(5);
    rchk(8'h89, 16'h000A);
    slope <= 16'hFFFE;
    ticks(3);
    rchk(8'h89, 16'h0014);
    hold <= 1'b1;
    pv_set <= 16'h0000;
    slope <= 16'h0000;
    // stage two's heat side has zero band: plain on/off
    wreg(8'h80, 16'h0001);
    ticks(30);
    rchk(8'h89, 16'h03E8);
    count_on(200);
    chk(16'(cnt), 16'h00C8, "heat on clocks");
    rchk(8'h8B, 16'h0001);
    pv_set <= 16'h0014;
    ticks(2);
    rchk(8'h89, 16'h0000);
    // integral: error clamped to the windup limit, then unwound
    wreg(8'h80, 16'h0000);
    wreg(8'h82, 16'h0000);
    pv_set <= 16'h0000;
    wreg(8'h83, 16'h0000);
    wreg(8'h02, 16'h0064);
    wreg(8'h03, 16'h0032);
    wreg(8'h05, 16'h001E);
    wreg(8'h82, 16'h001E);
    ticks(405);
    rchk(8'h8C, 16'h000A);
    pv_set <= 16'h0028;
    ticks(100);
    rchk(8'h8C, 16'h0005);
    // reset in mid-run clears outputs and restores defaults
    @(posedge clk);
    rst <= 1'b1;
    ticks(1);
    chk({rdata[13:0], heat_out, cool_out}, 16'h0000, "outputs in reset");
    rst <= 1'b0;
    rchk(8'h05, 16'h000A);
    rchk(8'h8C, 16'h0000);
    end_sim();
  end
endmodule : pid_time_proportioning_core_tb
bind pid_time_proportioning_core pid_core_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pv_in(pv_in), .heat_out(heat_out), .cool_out(cool_out));
`default_nettype wire
